// ---- src/taq_pkg.sv ----
// package of constants and types for the trace acquisition qualifier
`default_nettype none
package taq_pkg;
  localparam int TAQ_AW        = 32;
  localparam int TAQ_DW        = 32;
  localparam int TAQ_NTYPE     = 3;
  localparam int TAQ_NSLOT     = 8;
  localparam int TAQ_SLOT_IW   = 3;
  localparam int TAQ_TYPE_IW   = 2;
  localparam logic [1:0] TAQ_TYPE_FIRST  = 2'h0;
  localparam logic [1:0] TAQ_TYPE_SECOND = 2'h1;
  localparam logic [1:0] TAQ_TYPE_THIRD  = 2'h2;

  typedef enum logic [1:0] {
    TAQ_MODE_OFF   = 2'h0,
    TAQ_MODE_RANGE = 2'h1,
    TAQ_MODE_STOP  = 2'h3
  } taq_mode_t;

  typedef enum logic [1:0] {
    TAQ_ST_IDLE     = 2'h0,
    TAQ_ST_RUN      = 2'h1,
    TAQ_ST_PARALLEL = 2'h3
  } taq_state_t;

  // one slot's condition items
  typedef struct packed {
    taq_mode_t          mode;
    logic               addr_en;
    logic               addr_range;
    logic               addr_inv;
    logic [TAQ_AW-1:0]  addr_lo;
    logic [TAQ_AW-1:0]  addr_hi;
    logic [TAQ_AW-1:0]  addr_mask;
    logic               data_en;
    logic               data_inv;
    logic [TAQ_DW-1:0]  data_val;
    logic [TAQ_DW-1:0]  data_mask;
    logic               rd_sel;
    logic               wr_sel;
  } taq_slot_t;

  // one completed bus cycle
  typedef struct packed {
    logic [TAQ_AW-1:0] addr;
    logic [TAQ_DW-1:0] data;
    logic              write;
    logic              internal;
  } taq_cycle_t;

  localparam taq_slot_t TAQ_SLOT_RESET = '0;
endpackage
`default_nettype wire

// ---- src/taq_slot_match.sv ----
// one condition slot evaluated against one bus cycle
`default_nettype none
module taq_slot_match
  import taq_pkg::*;
#(
  parameter bit INV_OK = 1'b0
) (
  // slot and cycle
  input  wire taq_slot_t  slot,
  input  wire taq_cycle_t cyc,
  // result
  output logic            hit
);
  wire addr_eq   = ((cyc.addr ^ slot.addr_lo) & ~slot.addr_mask) == '0;
  wire addr_in   = (cyc.addr >= slot.addr_lo) && (cyc.addr <= slot.addr_hi);
  wire addr_raw  = slot.addr_range ? addr_in : addr_eq;
  // invert is honoured only where the type allows it
  wire addr_ok   = addr_raw ^ (INV_OK & slot.addr_inv);
  // always full width; narrower matches come from the mask
  wire data_eq   = ((cyc.data ^ slot.data_val) & ~slot.data_mask) == '0;
  wire data_ok   = data_eq ^ (INV_OK & slot.data_inv);
  wire dir_ok    = (cyc.write & slot.wr_sel) | (~cyc.write & slot.rd_sel);
  wire dir_given = slot.rd_sel | slot.wr_sel;
  // and of the given items, order free
  assign hit = (slot.mode != TAQ_MODE_OFF)
             && (!slot.addr_en || addr_ok)
             && (!slot.data_en || data_ok)
             && (!dir_given || dir_ok);
endmodule
`default_nettype wire

// ---- src/taq_qualifier.sv ----
// trace acquisition qualifier: slot store, evaluation and trace gating
`default_nettype none
module taq_qualifier
  import taq_pkg::*;
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rstn,
  // host commands, one-cycle pulses
  input  wire logic                   run_cmd,
  input  wire logic                   halt_cmd,
  input  wire logic                   leave_parallel_cmd,
  input  wire logic                   slot_set,
  input  wire logic                   slot_cancel,
  input  wire logic                   slot_all,
  input  wire logic [TAQ_TYPE_IW-1:0] slot_type,
  input  wire logic [TAQ_SLOT_IW-1:0] slot_num,
  input  wire taq_slot_t              slot_wdata,
  // slot readback
  input  wire logic [TAQ_TYPE_IW-1:0] rd_type,
  input  wire logic [TAQ_SLOT_IW-1:0] rd_num,
  output taq_slot_t                   rd_slot,
  // target bus, completed cycles
  input  wire logic                   bus_done,
  input  wire taq_cycle_t             bus_cycle,
  // trace outputs
  output logic                        trace_rec,
  output taq_cycle_t                  trace_cycle,
  output logic                        trace_stop_pulse,
  output logic                        trace_stopped,
  output logic                        parallel_mode,
  output logic                        emulating,
  output logic                        free_trace
);
  localparam int NS = TAQ_NTYPE * TAQ_NSLOT;

  taq_slot_t  slot_reg [NS];
  taq_state_t state_reg;
  taq_state_t state_next;
  logic       rec_reg;
  logic       stop_reg;
  logic       stopped_reg;
  taq_cycle_t cyc_reg;

  logic [NS-1:0] hit;
  logic [NS-1:0] used;
  logic [NS-1:0] is_range;
  logic [NS-1:0] is_stop;

  // slot store and matchers, one per entry
  genvar g;
  generate
    for (g = 0; g < NS; g++) begin : g_slot
      localparam logic [TAQ_TYPE_IW-1:0] TY = TAQ_TYPE_IW'(g / TAQ_NSLOT);
      localparam logic [TAQ_SLOT_IW-1:0] NO = TAQ_SLOT_IW'(g % TAQ_NSLOT);
      wire sel = (slot_type == TY) && (slot_all || slot_num == NO);
      taq_slot_t slot_next;
      // cancel wins over a set aimed at the same slot
      assign slot_next = (slot_cancel && sel) ? TAQ_SLOT_RESET
                       : (slot_set && sel)    ? slot_wdata
                       :                        slot_reg[g];
      always_ff @(posedge clk) begin
        if (!rstn) begin
          slot_reg[g] <= TAQ_SLOT_RESET;
        end else begin
          slot_reg[g] <= slot_next;
        end
      end
      taq_slot_match #(
        .INV_OK (TY == TAQ_TYPE_SECOND)
      ) u_match (
        .slot (slot_reg[g]),
        .cyc  (bus_cycle),
        .hit  (hit[g])
      );
      assign used[g]     = slot_reg[g].mode != TAQ_MODE_OFF;
      assign is_range[g] = slot_reg[g].mode == TAQ_MODE_RANGE;
      assign is_stop[g]  = slot_reg[g].mode == TAQ_MODE_STOP;
    end
  endgenerate

  // readback is registered, one cycle behind its select; an unused type code reads as empty
  localparam int RIW = $clog2(NS);
  taq_slot_t     rd_reg;
  taq_slot_t     rd_next;
  wire           rd_ok  = rd_type < TAQ_TYPE_IW'(TAQ_NTYPE);
  wire [RIW-1:0] rd_idx = RIW'(32'(rd_type) * TAQ_NSLOT + 32'(rd_num));
  assign rd_next = rd_ok ? slot_reg[rd_idx] : TAQ_SLOT_RESET;

  // decision for the cycle that just completed
  wire no_slots   = used == '0;
  wire range_set  = |is_range;
  wire range_hit  = |(hit & is_range);
  wire stop_hit   = |(hit & is_stop);
  wire running    = state_reg == TAQ_ST_RUN;
  wire sample     = running && bus_done;
  // stop-only slots leave every other cycle recorded
  wire want       = no_slots || !range_set || range_hit;
  wire do_stop    = sample && stop_hit;
  // the stopping cycle itself is still recorded when it qualifies
  wire do_rec     = sample && want && !bus_cycle.internal;

  // next values of the registered results
  wire        rec_next     = do_rec;
  wire        stop_next    = do_stop;
  wire        stop_clear   = leave_parallel_cmd || run_cmd;
  // sticky stop flag; a new stop wins over the clear
  wire        stopped_next = do_stop || (stopped_reg && !stop_clear);
  taq_cycle_t cyc_next;
  // the last completed cycle is held until the next one
  assign cyc_next = bus_done ? bus_cycle : cyc_reg;

  // halt wins over a stop or a leave in the same cycle
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      TAQ_ST_IDLE: begin
        if (run_cmd) begin
          state_next = TAQ_ST_RUN;
        end
      end
      TAQ_ST_RUN: begin
        if (halt_cmd) begin
          state_next = TAQ_ST_IDLE;
        end else if (do_stop) begin
          state_next = TAQ_ST_PARALLEL;
        end
      end
      TAQ_ST_PARALLEL: begin
        if (halt_cmd) begin
          state_next = TAQ_ST_IDLE;
        end else if (leave_parallel_cmd) begin
          state_next = TAQ_ST_RUN;
        end
      end
      default: begin
        state_next = TAQ_ST_IDLE;
      end
    endcase
  end

  // the decision reads state_reg, so a command applies from the next completed cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg <= TAQ_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // pulses stand one cycle each: their next values carry no hold term
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rec_reg <= 1'b0;
    end else begin
      rec_reg <= rec_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      stop_reg <= 1'b0;
    end else begin
      stop_reg <= stop_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      stopped_reg <= 1'b0;
    end else begin
      stopped_reg <= stopped_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cyc_reg <= '0;
    end else begin
      cyc_reg <= cyc_next;
    end
  end

  // readback serves the host only and never feeds the decision
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rd_reg <= TAQ_SLOT_RESET;
    end else begin
      rd_reg <= rd_next;
    end
  end

  assign rd_slot          = rd_reg;
  assign trace_rec        = rec_reg;
  assign trace_cycle      = cyc_reg;
  assign trace_stop_pulse = stop_reg;
  assign trace_stopped    = stopped_reg;
  assign parallel_mode    = state_reg == TAQ_ST_PARALLEL;
  assign emulating        = state_reg != TAQ_ST_IDLE;
  assign free_trace       = no_slots;
endmodule
`default_nettype wire

// ---- dv/taq_monitor.sv ----
// checker of trace gating at the qualifier ports
`default_nettype none
module taq_monitor
  import taq_pkg::*;
(
  // clock, reset and commands
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       halt_cmd,
  input wire logic       leave_parallel_cmd,
  // bus side
  input wire logic       bus_done,
  input wire taq_cycle_t bus_cycle,
  // trace side
  input wire logic       trace_rec,
  input wire taq_cycle_t trace_cycle,
  input wire logic       trace_stop_pulse,
  input wire logic       trace_stopped,
  input wire logic       parallel_mode,
  input wire logic       emulating,
  input wire logic       free_trace
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_idle; !emulating |=> !trace_rec; endproperty
  a_idle: assert property (p_idle) else $error("record while idle");
  property p_free; free_trace && emulating && !parallel_mode && bus_done && !bus_cycle.internal |=> trace_rec; endproperty
  a_free: assert property (p_free) else $error("free trace dropped a cycle");
  property p_int; bus_done && bus_cycle.internal |=> !trace_rec; endproperty
  a_int: assert property (p_int) else $error("internal cycle recorded");
  property p_cyc; bus_done |=> trace_cycle == $past(bus_cycle); endproperty
  a_cyc: assert property (p_cyc) else $error("recorded cycle differs");
  property p_nobus; !bus_done |=> !trace_rec && !trace_stop_pulse; endproperty
  a_nobus: assert property (p_nobus) else $error("event without bus cycle");
  property p_par; parallel_mode |=> !trace_rec; endproperty
  a_par: assert property (p_par) else $error("record in parallel mode");
  property p_leave; parallel_mode && leave_parallel_cmd && !halt_cmd |=> !parallel_mode && !trace_stopped; endproperty
  a_leave: assert property (p_leave) else $error("leave not taken");
  property p_stop; trace_stop_pulse |-> trace_stopped; endproperty
  a_stop: assert property (p_stop) else $error("stop not reported");
  property p_rose; $rose(parallel_mode) |-> trace_stop_pulse; endproperty
  a_rose: assert property (p_rose) else $error("parallel without stop");
  property p_halt; halt_cmd |=> !emulating && !parallel_mode; endproperty
  a_halt: assert property (p_halt) else $error("halt not taken");
endmodule
bind taq_qualifier taq_monitor u_mon (.clk, .rstn, .halt_cmd, .leave_parallel_cmd, .bus_done, .bus_cycle,
  .trace_rec, .trace_cycle, .trace_stop_pulse, .trace_stopped, .parallel_mode, .emulating, .free_trace);
`default_nettype wire

// ---- dv/taq_bus_model.sv ----
// target bus model handing completed cycles to the qualifier
`default_nettype none
module taq_bus_model
  import taq_pkg::*;
(
  // clock
  input  wire logic       clk,
  // request from the bench
  input  wire logic       req,
  input  wire taq_cycle_t cyc,
  // completed cycle towards the qualifier
  output logic            bus_done,
  output taq_cycle_t      bus_cycle
);
  timeunit 1ns;
  timeprecision 1ps;
  initial bus_done = 1'b0;
  initial bus_cycle = '0;
  // lines go to junk between cycles so a late read shows up
  always @(posedge clk) begin
    bus_done <= req;
    bus_cycle <= req ? cyc : ~bus_cycle;
  end
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// testbench for the trace acquisition qualifier
`default_nettype none
module tb_top
  import taq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rstn = 0, run_c = 0, leave_c = 0, set_c = 0, can_c = 0, all_c = 0, req = 0, bus_done;
  logic halt_c = 0;
  logic [1:0] s_type = 0, r_type = 0;
  logic [2:0] s_num = 0, r_num = 0;
  taq_slot_t s = '0, rd_slot;
  taq_cycle_t cyc = '0, bus_cycle, trace_cycle, q[$];
  logic trace_rec, stp, stopped, par, emu, free;
  int bad_count = 0, num_checks = 0, seed = 80, stops = 0;
  taq_bus_model u_bus (.clk(clk), .req(req), .cyc(cyc), .bus_done(bus_done), .bus_cycle(bus_cycle));
  taq_qualifier u_dut (.clk(clk), .rstn(rstn), .run_cmd(run_c), .halt_cmd(halt_c), .leave_parallel_cmd(leave_c),
    .slot_set(set_c), .slot_cancel(can_c), .slot_all(all_c), .slot_type(s_type), .slot_num(s_num),
    .slot_wdata(s), .rd_type(r_type), .rd_num(r_num), .rd_slot(rd_slot), .bus_done(bus_done),
    .bus_cycle(bus_cycle), .trace_rec(trace_rec), .trace_cycle(trace_cycle), .trace_stop_pulse(stp),
    .trace_stopped(stopped), .parallel_mode(par), .emulating(emu), .free_trace(free));
  task close_out;
    if (bad_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [199:0] seen, input logic [199:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: value differs", $time);
    end
  endtask
  task tick(input int n); repeat (n) @(negedge clk); endtask
  task cmd(input logic r, l, st, cn, al);
    {run_c, leave_c, set_c, can_c, all_c} = {r, l, st, cn, al};
    tick(1);
    {run_c, leave_c, set_c, can_c, all_c} = '0;
    tick(1);
  endtask
  // noting the expectation before the request keeps queue order equal to bus order
  task bus(input logic [31:0] a, d, input logic w, i, e);
    cyc = '{a, d, w, i};
    if (e) q.push_back(cyc);
    req = 1;
    tick(1);
    req = 0;
    tick(1);
  endtask
  initial forever #4 clk = ~clk;
  initial begin
    #20000;
    bad_count++;
    close_out;
  end
  always @(negedge clk) begin
    if (stp) stops++;
    if (trace_rec && q.size() == 0) chk(1, 0);
    else if (trace_rec) chk(trace_cycle, q.pop_front());
  end
  initial begin
    tick(16);
    rstn = 1;
    bus(32'h10, 32'h1, 0, 0, 0);
    cmd(1, 0, 0, 0, 0);
    chk(emu, 1);
    repeat (8) bus($random(seed), $random(seed), 1'($random(seed)), 0, 1);
    bus(32'h20, 32'h2, 1, 1, 0);
    s.mode = TAQ_MODE_RANGE; s.addr_en = 1; s.addr_range = 1; s.addr_lo = 32'h100; s.addr_hi = 32'h1FF;
    s_type = TAQ_TYPE_SECOND; s_num = 3'h5; cmd(0, 0, 1, 0, 0);
    r_type = s_type; r_num = s_num; tick(1);
    chk(rd_slot, s);
    chk(free, 0);
    bus(32'hFF, 0, 0, 0, 0); bus(32'h100, 0, 0, 0, 1); bus(32'h1FF, 0, 1, 0, 1); bus(32'h200, 0, 0, 0, 0);
    s = '0; s.mode = TAQ_MODE_RANGE; s.addr_en = 1; s.addr_inv = 1; s.addr_lo = 32'h1000; s.addr_mask = 32'hF;
    s.data_en = 1; s.data_val = 32'hAB; s.data_mask = 32'hFFFFFF00; s.wr_sel = 1;
    s_type = TAQ_TYPE_FIRST; s_num = 3'h7; cmd(0, 0, 1, 0, 0);
    bus(32'h1003, 32'h55AB, 1, 0, 1); bus(32'h1003, 32'h55AB, 0, 0, 0);
    bus(32'h1013, 32'hAB, 1, 0, 0); bus(32'h1003, 32'hAC, 1, 0, 0);
    s = '0; s.mode = TAQ_MODE_RANGE; s.addr_en = 1; s.addr_inv = 1; s.addr_lo = 32'h3000; s.rd_sel = 1;
    s.data_en = 1; s.data_inv = 1; s.data_val = 32'h77;
    s_type = TAQ_TYPE_SECOND; s_num = 3'h0; cmd(0, 0, 1, 0, 0);
    bus(32'h3004, 32'h78, 0, 0, 1); bus(32'h3000, 32'h78, 0, 0, 0); bus(32'h3004, 32'h77, 0, 0, 0);
    for (int t = 0; t < 2; t++) begin
      s_type = 2'(t); cmd(0, 0, 0, 1, 1);
    end
    chk(free, 1);
    s = '0; s.mode = TAQ_MODE_STOP; s.addr_en = 1; s.addr_lo = 32'h500;
    s_type = TAQ_TYPE_THIRD; cmd(0, 0, 1, 0, 1);
    r_type = s_type; r_num = 3'h7; tick(1);
    chk(rd_slot, s);
    bus(32'h400, 0, 0, 0, 1); bus(32'h500, 0, 0, 1, 0); bus(32'h600, 0, 0, 0, 0); tick(3);
    chk({stops, stopped, par}, {32'd1, 2'b11});
    cmd(0, 1, 0, 0, 0); tick(1);
    chk({stopped, par}, 2'b00);
    bus(32'h700, 0, 0, 0, 1);
    cmd(0, 0, 0, 1, 1); tick(1);
    chk(free, 1);
    halt_c = 1; tick(1);
    halt_c = 0; tick(1);
    chk(emu, 0);
    bus(32'h800, 0, 0, 0, 0);
    tick(4);
    chk(q.size(), 0);
    close_out;
  end
endmodule
`default_nettype wire
